// File: ckg_pkg.sv
// ----------------------------------------------------------------------------
// Shared constants for the clock generator control and status block.
// ----------------------------------------------------------------------------
package ckg_pkg;

    // ------------------------------------------------------------------------
    // Register byte addresses on the APB.
    // ------------------------------------------------------------------------
    localparam logic [7:0] CTRL_TWO_ADDR = 8'h00; // Control register two.
    localparam logic [7:0] STATUS_ONE_ADDR = 8'h04; // Status register one.
    localparam logic [7:0] MODE_CFG_ADDR = 8'h08; // Mode and detection setup.

    // ------------------------------------------------------------------------
    // Control register two field positions.
    // ------------------------------------------------------------------------
    localparam int LOCK_LOSS_SEL_BIT = 7; // Lock loss response select.
    localparam int MULT_LSB = 4; // Loop multiplier field, low bit.
    localparam int CLOCK_LOSS_SEL_BIT = 3; // Clock loss response select.
    localparam int DIV_LSB = 0; // Output divider field, low bit.

    // ------------------------------------------------------------------------
    // Status register one field positions.
    // ------------------------------------------------------------------------
    localparam int MODE_STATUS_LSB = 6; // Mode status field, low bit.
    localparam int REF_STATUS_BIT = 5; // Reference status.
    localparam int LOCK_LOSS_FLAG_BIT = 4; // Sticky lock loss flag.
    localparam int LOCK_BIT = 3; // Live lock state.
    localparam int CLOCK_LOSS_FLAG_BIT = 2; // Sticky clock loss flag.
    localparam int EXT_REF_OK_BIT = 1; // External reference valid.
    localparam int IRQ_FLAG_BIT = 0; // Interrupt flag.

    // ------------------------------------------------------------------------
    // Mode configuration register field positions.
    // ------------------------------------------------------------------------
    localparam int MODE_SEL_LSB = 0; // Mode select field, low bit.
    localparam int REF_SEL_BIT = 2; // 1 selects crystal, 0 external clock.
    localparam int LOSS_DIS_BIT = 3; // Clock loss detection disable.

    // ------------------------------------------------------------------------
    // Reset values.
    // ------------------------------------------------------------------------
    localparam logic [7:0] CTRL_TWO_RESET = 8'h00; // Control two after reset.
    localparam logic [7:0] MODE_CFG_RESET = 8'h00; // Self-clocked, detect on.

    // ------------------------------------------------------------------------
    // Clock modes as reported and selected.
    // ------------------------------------------------------------------------
    localparam logic [1:0] MODE_SELF = 2'h0; // Self-clocked.
    localparam logic [1:0] MODE_ENG_INT = 2'h1; // Loop engaged, internal ref.
    localparam logic [1:0] MODE_BYP_EXT = 2'h2; // Loop bypassed, external ref.
    localparam logic [1:0] MODE_ENG_EXT = 2'h3; // Loop engaged, external ref.

    // ------------------------------------------------------------------------
    // Timing.
    // ------------------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 8; // Bus clock period at 125 MHz.
    localparam int FIELD_APPLY_NS = 64; // Least time to complete a field write.
    localparam int FIELD_APPLY_CYCLES = (FIELD_APPLY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int MODE_SYNC_STAGES = 2; // Stages the mode passes through.

    // Clearing sequence of the interrupt flag.
    typedef enum logic {
        CLR_IDLE,
        CLR_ARMED
    } ckg_clr_state_t;

endpackage

// File: ckg_field_apply.sv
`timescale 1ns/100ps
// ----------------------------------------------------------------------------
// Holds one control field and applies a new value only after a fixed
// completion time; writes arriving meanwhile are dropped.
// ----------------------------------------------------------------------------
module ckg_field_apply #(
    parameter int WIDTH = 3,
    parameter int CYCLES = ckg_pkg::FIELD_APPLY_CYCLES
) (
    input wire logic pclk, // Bus clock.
    input wire logic presetn, // Asynchronous reset, active low.
    input wire logic wr, // Write strobe for this field.
    input wire logic [WIDTH-1:0] wdata, // Value written.
    output logic [WIDTH-1:0] value, // Value now in effect.
    output logic [WIDTH-1:0] pend, // Value last accepted.
    output logic busy // A write is still completing.
);

    // Refuse settings the counter cannot hold.
    initial begin
        if (CYCLES < 1 || CYCLES > 255 || WIDTH < 1) begin
            $error("ckg_field_apply: bad parameters");
        end
    end

    // All state of this module.
    typedef struct packed {
        logic [WIDTH-1:0] value;
        logic [WIDTH-1:0] pend;
        logic [7:0] cnt;
    } ckg_fa_state_t;

    ckg_fa_state_t s_q; // Registered state.
    ckg_fa_state_t s_d; // Next state.

    // ------------------------------------------------------------------------
    // Next state.
    // ------------------------------------------------------------------------
    // A new value is taken only while no earlier one is completing.
    always_comb begin
        s_d = s_q;
        if (s_q.cnt != 8'h00) begin
            s_d.cnt = s_q.cnt - 8'h01;
            if (s_q.cnt == 8'h01) begin
                s_d.value = s_q.pend;
            end
        end else if (wr) begin
            s_d.pend = wdata;
            s_d.cnt = 8'(CYCLES);
        end
    end

    // Register the state.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign value = s_q.value;
    assign pend = s_q.pend;
    assign busy = (s_q.cnt != 8'h00);

    // A write while busy leaves the accepted value alone.
    property p_busy_ignore;
        @(posedge pclk) disable iff (!presetn)
        (wr && busy) |=> (pend == $past(pend));
    endproperty
    a_busy_ignore: assert property (p_busy_ignore) else $error("write taken while busy");

    // An accepted write is in effect right after the edge CYCLES later.
    property p_apply_time;
        @(posedge pclk) disable iff (!presetn)
        (wr && !busy) |=> ##CYCLES (value == $past(wdata, CYCLES + 1));
    endproperty
    a_apply_time: assert property (p_apply_time) else $error("field not applied in time");

endmodule

// File: ckg_ctrl.sv
// The implementer's own choices: the register addresses and the APB slave port.
`timescale 1ns/100ps
// ----------------------------------------------------------------------------
// Clock generator control and status, reached over APB.
// ----------------------------------------------------------------------------
module ckg_ctrl (
    input wire logic pclk, // Bus clock, 125 MHz.
    input wire logic presetn, // Asynchronous reset, active low.
    input wire logic psel, // APB select.
    input wire logic penable, // APB enable.
    input wire logic pwrite, // APB direction, 1 writes.
    input wire logic [7:0] paddr, // APB byte address.
    input wire logic [31:0] pwdata, // APB write data.
    output logic [31:0] prdata, // APB read data.
    output logic pready, // APB ready.
    output logic pslverr, // APB error on unmapped address.
    input wire logic loop_locked, // Loop reports lock.
    input wire logic clock_lost, // Loss of clock seen, one-cycle pulse.
    input wire logic ext_ref_ok, // External reference stable and fast enough.
    output logic [4:0] loop_multiplier_n, // Multiplication factor in effect.
    output logic [7:0] output_divider_r, // Division factor in effect.
    output logic [1:0] mode_status, // Clock mode in effect.
    output logic irq, // Interrupt request level.
    output logic reset_req // Reset request, one-cycle pulse.
);

    // ------------------------------------------------------------------------
    // State.
    // ------------------------------------------------------------------------
    typedef struct packed {
        logic lock_loss_sel; // Lock loss response select.
        logic clock_loss_sel; // Clock loss response select.
        logic [1:0] mode_select; // Requested clock mode.
        logic ref_sel; // Reference source select.
        logic loss_dis; // Clock loss detection disable.
        logic [ckg_pkg::MODE_SYNC_STAGES*2-1:0] mode_sync; // Mode crossing stages.
        logic lock_loss_flag; // Sticky lock loss.
        logic clock_loss_flag; // Sticky clock loss.
        logic irq_flag; // Interrupt pending.
        ckg_pkg::ckg_clr_state_t clr; // Clearing sequence state.
        logic locked_prev; // Lock seen last cycle.
        logic reset_req; // Reset request pulse.
        logic [7:0] rdata; // Read data.
        logic err; // Error answer.
    } ckg_state_t;

    ckg_state_t s_q; // Registered state.
    ckg_state_t s_d; // Next state.

    // ------------------------------------------------------------------------
    // Field applicators for the multiplier and divider.
    // ------------------------------------------------------------------------
    logic mult_wr; // Multiplier field write.
    logic div_wr; // Divider field write.
    logic [2:0] mult_code; // Multiplier code in effect.
    logic [2:0] div_code; // Divider code in effect.
    logic [2:0] mult_pend; // Multiplier code last accepted.
    logic [2:0] div_pend; // Divider code last accepted.
    logic mult_busy; // Multiplier write completing.
    logic div_busy; // Divider write completing.

    // Multiplier write ignored while busy.
    // field applicator
    ckg_field_apply #(.WIDTH(3), .CYCLES(ckg_pkg::FIELD_APPLY_CYCLES)) u_mult (
        .pclk(pclk),
        .presetn(presetn),
        .wr(mult_wr),
        .wdata(pwdata[ckg_pkg::MULT_LSB +: 3]),
        .value(mult_code),
        .pend(mult_pend),
        .busy(mult_busy)
    );

    // Divider write ignored while busy.
    // field applicator
    ckg_field_apply #(.WIDTH(3), .CYCLES(ckg_pkg::FIELD_APPLY_CYCLES)) u_div (
        .pclk(pclk),
        .presetn(presetn),
        .wr(div_wr),
        .wdata(pwdata[ckg_pkg::DIV_LSB +: 3]),
        .value(div_code),
        .pend(div_pend),
        .busy(div_busy)
    );

    // ------------------------------------------------------------------------
    // Decode.
    // ------------------------------------------------------------------------
    logic access; // Access phase; every access completes at once.
    logic setup; // Setup phase.
    logic hit_ctrl; // Control two addressed.
    logic hit_stat; // Status one addressed.
    logic hit_cfg; // Mode configuration addressed.
    logic engaged; // Loop engaged in the reported mode.
    logic lock_now; // Live lock state as reported.
    logic lock_loss_ev; // Unexpected loss of lock this cycle.
    logic clock_loss_ev; // Detected loss of clock this cycle.
    logic irq_ev; // New interrupt request this cycle.
    logic [7:0] stat_word; // Status register contents.
    logic [7:0] ctrl_word; // Control register contents.
    logic [7:0] cfg_word; // Configuration register contents.

    assign access = psel && penable;
    assign setup = psel && !penable;
    assign hit_ctrl = (paddr == ckg_pkg::CTRL_TWO_ADDR);
    assign hit_stat = (paddr == ckg_pkg::STATUS_ONE_ADDR);
    assign hit_cfg = (paddr == ckg_pkg::MODE_CFG_ADDR);
    assign mult_wr = access && pwrite && hit_ctrl;
    assign div_wr = access && pwrite && hit_ctrl;

    // Lock is only reported while the loop is engaged.
    // lock gated
    assign engaged = (s_q.mode_sync[1:0] == ckg_pkg::MODE_ENG_INT) ||
                     (s_q.mode_sync[1:0] == ckg_pkg::MODE_ENG_EXT);
    assign lock_now = loop_locked && engaged;

    // A fall of lock while engaged counts as an unexpected loss.
    assign lock_loss_ev = s_q.locked_prev && !loop_locked && engaged;

    // Clock loss is ignored while detection is disabled.
    // detection gate
    assign clock_loss_ev = clock_lost && !s_q.loss_dis;

    // A loss whose select is 0 raises an interrupt.
    // interrupt routing
    assign irq_ev = (lock_loss_ev && !s_q.lock_loss_sel) || (clock_loss_ev && !s_q.clock_loss_sel);

    // Status word assembly.
    // reference status
    always_comb begin
        stat_word = 8'h00;
        stat_word[ckg_pkg::MODE_STATUS_LSB +: 2] = s_q.mode_sync[1:0];
        stat_word[ckg_pkg::REF_STATUS_BIT] = s_q.ref_sel;
        stat_word[ckg_pkg::LOCK_LOSS_FLAG_BIT] = s_q.lock_loss_flag;
        stat_word[ckg_pkg::LOCK_BIT] = lock_now;
        stat_word[ckg_pkg::CLOCK_LOSS_FLAG_BIT] = s_q.clock_loss_flag;
        stat_word[ckg_pkg::EXT_REF_OK_BIT] = ext_ref_ok;
        stat_word[ckg_pkg::IRQ_FLAG_BIT] = s_q.irq_flag;
    end

    // Control and configuration word assembly; pending codes read back.
    always_comb begin
        ctrl_word = 8'h00;
        ctrl_word[ckg_pkg::LOCK_LOSS_SEL_BIT] = s_q.lock_loss_sel;
        ctrl_word[ckg_pkg::MULT_LSB +: 3] = mult_pend;
        ctrl_word[ckg_pkg::CLOCK_LOSS_SEL_BIT] = s_q.clock_loss_sel;
        ctrl_word[ckg_pkg::DIV_LSB +: 3] = div_pend;
        cfg_word = 8'h00;
        cfg_word[ckg_pkg::MODE_SEL_LSB +: 2] = s_q.mode_select;
        cfg_word[ckg_pkg::REF_SEL_BIT] = s_q.ref_sel;
        cfg_word[ckg_pkg::LOSS_DIS_BIT] = s_q.loss_dis;
    end

    // ------------------------------------------------------------------------
    // Next state.
    // ------------------------------------------------------------------------
    always_comb begin
        s_d = s_q;
        s_d.locked_prev = loop_locked;
        s_d.reset_req = 1'b0;
        s_d.err = 1'b0;

        // Read data is captured in the setup phase.
        if (setup) begin
            if (hit_ctrl) begin
                s_d.rdata = ctrl_word;
            end else if (hit_stat) begin
                s_d.rdata = stat_word;
            end else if (hit_cfg) begin
                s_d.rdata = cfg_word;
            end else begin
                s_d.rdata = 8'h00;
                s_d.err = 1'b1;
            end
        end

        // Mode passes through synchronising stages before it is reported.
        // mode crossing
        s_d.mode_sync = {s_q.mode_select, s_q.mode_sync[ckg_pkg::MODE_SYNC_STAGES*2-1:2]};

        // Register writes.
        if (access && pwrite) begin
            if (hit_ctrl) begin
                s_d.lock_loss_sel = pwdata[ckg_pkg::LOCK_LOSS_SEL_BIT];
                s_d.clock_loss_sel = pwdata[ckg_pkg::CLOCK_LOSS_SEL_BIT];
            end else if (hit_cfg) begin
                s_d.mode_select = pwdata[ckg_pkg::MODE_SEL_LSB +: 2];
                s_d.ref_sel = pwdata[ckg_pkg::REF_SEL_BIT];
                s_d.loss_dis = pwdata[ckg_pkg::LOSS_DIS_BIT];
            end else if (hit_stat) begin
                // Loss flags clear on a one written.
                if (pwdata[ckg_pkg::LOCK_LOSS_FLAG_BIT]) begin
                    s_d.lock_loss_flag = 1'b0;
                end
                if (pwdata[ckg_pkg::CLOCK_LOSS_FLAG_BIT]) begin
                    s_d.clock_loss_flag = 1'b0;
                end
                // A one after an armed read clears; a zero does nothing.
                // zero ignored
                if (pwdata[ckg_pkg::IRQ_FLAG_BIT] && s_q.clr == ckg_pkg::CLR_ARMED) begin
                    s_d.irq_flag = 1'b0;
                    s_d.clr = ckg_pkg::CLR_IDLE;
                end
            end
        end

        // Reading status with the flag set arms the clear.
        if (access && !pwrite && hit_stat && s_q.irq_flag) begin
            s_d.clr = ckg_pkg::CLR_ARMED;
        end

        // Loss events set the sticky flags; set wins over clear.
        // lock loss sticky
        if (lock_loss_ev) begin
            s_d.lock_loss_flag = 1'b1;
        end
        if (clock_loss_ev) begin
            s_d.clock_loss_flag = 1'b1;
        end

        // Select bits choose reset or interrupt for a fresh flag.
        // lock response
        if ((lock_loss_ev && s_q.lock_loss_sel) || (clock_loss_ev && s_q.clock_loss_sel)) begin
            s_d.reset_req = 1'b1;
        end

        // A new interrupt sets the flag and restarts the clear.
        // flag pending
        if (irq_ev) begin
            s_d.irq_flag = 1'b1;
            s_d.clr = ckg_pkg::CLR_IDLE;
        end
    end

    // Register the state.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q <= '0;
            s_q.lock_loss_sel <= ckg_pkg::CTRL_TWO_RESET[ckg_pkg::LOCK_LOSS_SEL_BIT];
            s_q.clock_loss_sel <= ckg_pkg::CTRL_TWO_RESET[ckg_pkg::CLOCK_LOSS_SEL_BIT];
            s_q.mode_select <= ckg_pkg::MODE_CFG_RESET[ckg_pkg::MODE_SEL_LSB +: 2];
            s_q.ref_sel <= ckg_pkg::MODE_CFG_RESET[ckg_pkg::REF_SEL_BIT];
            s_q.loss_dis <= ckg_pkg::MODE_CFG_RESET[ckg_pkg::LOSS_DIS_BIT];
        end else begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------------------
    // Outputs.
    // ------------------------------------------------------------------------
    // Multiplier decode; the unused top code repeats the largest factor.
    // multiplier decode
    always_comb begin
        case (mult_code)
            3'h6: loop_multiplier_n = 5'h12;
            3'h7: loop_multiplier_n = 5'h12;
            default: loop_multiplier_n = 5'(({2'h0, mult_code} << 1) + 5'h04);
        endcase
    end

    // Divider is a power of two.
    // divider decode
    assign output_divider_r = 8'h01 << div_code;

    // Mode status is the last synchronising stage.
    // mode report
    assign mode_status = s_q.mode_sync[1:0];
    assign irq = s_q.irq_flag;
    assign reset_req = s_q.reset_req;
    assign prdata = {24'h000000, s_q.rdata};
    assign pready = 1'b1;
    assign pslverr = access && s_q.err;

    // ------------------------------------------------------------------------
    // Checks.
    // ------------------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_lock_irq;
        lock_loss_ev && !s_q.lock_loss_sel && !clock_loss_ev |=> irq && !reset_req;
    endproperty
    a_lock_irq: assert property (p_lock_irq) else $error("lock loss did not interrupt");

    property p_lock_rst;
        lock_loss_ev && s_q.lock_loss_sel && !irq_ev && !irq |=> reset_req && !irq && s_q.lock_loss_flag;
    endproperty
    a_lock_rst: assert property (p_lock_rst) else $error("lock loss did not reset");

    property p_clk_rst;
        clock_loss_ev && s_q.clock_loss_sel |=> reset_req && s_q.clock_loss_flag;
    endproperty
    a_clk_rst: assert property (p_clk_rst) else $error("clock loss did not reset");

    property p_mult_18;
        mult_code == 3'h6 |-> loop_multiplier_n == 5'h12;
    endproperty
    a_mult_18: assert property (p_mult_18) else $error("code six not eighteen");

    property p_div_max;
        div_code == 3'h7 |-> output_divider_r == 8'h80;
    endproperty
    a_div_max: assert property (p_div_max) else $error("code seven not 128");

    property p_mode_lag;
        ##2 mode_status == $past(s_q.mode_select, 2);
    endproperty
    a_mode_lag: assert property (p_mode_lag) else $error("mode status lag wrong");

    property p_lock_gate;
        !engaged |-> !stat_word[ckg_pkg::LOCK_BIT];
    endproperty
    a_lock_gate: assert property (p_lock_gate) else $error("lock shown while not engaged");

    property p_loss_dis;
        s_q.loss_dis && !s_q.clock_loss_flag && !(access && pwrite && hit_cfg) |=> !s_q.clock_loss_flag;
    endproperty
    a_loss_dis: assert property (p_loss_dis) else $error("clock loss seen while disabled");

    property p_irq_restart;
        irq_ev |=> irq && s_q.clr == ckg_pkg::CLR_IDLE;
    endproperty
    a_irq_restart: assert property (p_irq_restart) else $error("new interrupt did not restart");

    property p_zero_write;
        access && pwrite && hit_stat && !pwdata[ckg_pkg::IRQ_FLAG_BIT] && irq |=> irq;
    endproperty
    a_zero_write: assert property (p_zero_write) else $error("zero write cleared flag");

endmodule

// File: tb_top.sv
`timescale 1ns/100ps
// ----------------------------------------------------------------------------
// Bench for the clock generator control block, driven over APB.
// ----------------------------------------------------------------------------
module tb_top;
    logic pclk = 1'b0; // Bus clock.
    logic presetn = 1'b0; // Reset, active low.
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0; // APB controls.
    logic [7:0] paddr = 8'h00; // APB address.
    logic [31:0] pwdata = 32'h0, prdata, rd; // APB data and last read.
    logic pready, pslverr, err; // APB answer and last error.
    logic loop_locked = 1'b0, clock_lost = 1'b0, ext_ref_ok = 1'b0; // Loop side.
    logic [4:0] loop_multiplier_n; // Factor in effect.
    logic [7:0] output_divider_r; // Divider in effect.
    logic [1:0] mode_status; // Mode in effect.
    logic irq, reset_req; // Requests.
    int error_cnt = 0, total_checks = 0, cyc = 0; // Counters.
    ckg_ctrl u_ckg_ctrl (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .loop_locked(loop_locked), .clock_lost(clock_lost), .ext_ref_ok(ext_ref_ok),
        .loop_multiplier_n(loop_multiplier_n), .output_divider_r(output_divider_r),
        .mode_status(mode_status), .irq(irq), .reset_req(reset_req));
    // The clock toggles every half period of 4 ns.
    initial begin
        forever #4 pclk = ~pclk;
    end
    // Prints the counts and the verdict, then ends the run.
    task automatic test_done();
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    // A hung run counts as a mismatch.
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 20000) begin
            error_cnt++;
            test_done();
        end
    end
    // Compares one value, counting it.
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch at %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // One APB transfer: setup, then access until pready is sampled high.
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1; pwrite <= wr; paddr <= a; pwdata <= d; penable <= 1'b0;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask
    // Waits n edges and lets their updates land.
    task automatic idle(input int n);
        repeat (n) @(posedge pclk);
        #1;
    endtask
    // One-cycle loss of clock pulse; returns just after the response edge.
    task automatic lose_clock();
        @(posedge pclk) clock_lost <= 1'b1;
        @(posedge pclk) clock_lost <= 1'b0;
        #1;
    endtask
    // ------------------------------------------------------------------------
    // Main sequence.
    // ------------------------------------------------------------------------
    initial begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        idle(1);
        chk(loop_multiplier_n, 32'h4); chk(output_divider_r, 32'h1);
        chk(pready, 32'h1);
        apb(1'b0, 8'h0c, 32'h0); chk(err, 32'h1); chk(rd, 32'h0);
        // Every multiplier and divider code, each given time to complete.
        for (int c = 0; c < 8; c++) begin
            apb(1'b1, 8'h00, 32'(c * 17));
            idle(10);
            chk(loop_multiplier_n, (c >= 6) ? 32'd18 : 32'(4 + 2 * c));
            chk(output_divider_r, 32'(1 << c));
        end
        // A second write at once is dropped for both fields.
        apb(1'b1, 8'h00, 32'h12);
        apb(1'b1, 8'h00, 32'h75);
        idle(10);
        chk(loop_multiplier_n, 32'h6);
        chk(output_divider_r, 32'h4);
        apb(1'b0, 8'h00, 32'h0); chk(rd, 32'h12);
        // Engaged mode with internal reference, crystal selected.
        apb(1'b1, 8'h08, 32'h05);
        loop_locked <= 1'b1; ext_ref_ok <= 1'b1;
        idle(3);
        chk(mode_status, 32'h1);
        apb(1'b0, 8'h04, 32'h0); chk(rd, 32'h6a);
        // Lock loss with interrupt response.
        loop_locked <= 1'b0;
        idle(3);
        chk(irq, 32'h1);
        apb(1'b0, 8'h04, 32'h0); chk(rd, 32'h73);
        apb(1'b1, 8'h04, 32'h0); idle(1); chk(irq, 32'h1);
        apb(1'b0, 8'h04, 32'h0);
        apb(1'b1, 8'h04, 32'h1); idle(1); chk(irq, 32'h0);
        // A new event between the read and the clearing write keeps the flag.
        lose_clock(); chk(irq, 32'h1);
        apb(1'b0, 8'h04, 32'h0);
        lose_clock();
        apb(1'b1, 8'h04, 32'h1); idle(1); chk(irq, 32'h1);
        apb(1'b0, 8'h04, 32'h0); chk(rd, 32'h77);
        apb(1'b1, 8'h04, 32'h15); idle(1); chk(irq, 32'h0);
        apb(1'b0, 8'h04, 32'h0); chk(rd, 32'h62);
        // Clock loss with reset response raises no interrupt.
        apb(1'b1, 8'h00, 32'h1a);
        lose_clock(); chk(reset_req, 32'h1); chk(irq, 32'h0);
        // With detection disabled a loss of clock leaves the flag clear.
        apb(1'b1, 8'h04, 32'h04);
        apb(1'b1, 8'h08, 32'h0d);
        lose_clock(); chk(reset_req, 32'h0);
        apb(1'b0, 8'h04, 32'h0); chk(rd, 32'h62);
        test_done();
    end
endmodule
